// *** logic/timer0_pkg.sv ***
package timer0_pkg;

  // Register offsets
  localparam logic [7:0] OFS_TIMER_COUNT         = 8'h01;
  localparam logic [7:0] OFS_INTERRUPT_CONTROL   = 8'h0B;
  localparam logic [7:0] OFS_TIMER_CONFIGURATION = 8'h81;

  // Reset values
  localparam logic [7:0] RST_TIMER_COUNT         = 8'h00;
  localparam logic [7:0] RST_INTERRUPT_CONTROL   = 8'h00;
  localparam logic [7:0] RST_TIMER_CONFIGURATION = 8'hFF;

  // Field positions in timer_configuration
  localparam int unsigned BIT_CLOCK_SOURCE_SELECT = 5;
  localparam int unsigned BIT_SOURCE_EDGE_SELECT  = 4;
  localparam int unsigned BIT_PRESCALER_ASSIGN    = 3;
  localparam int unsigned BIT_PRESCALE_RATIO_LSB  = 0;
  localparam int unsigned PRESCALE_RATIO_WIDTH    = 3;

  // Field positions in interrupt_control
  localparam int unsigned BIT_OVERFLOW_IRQ_ENABLE = 5;
  localparam int unsigned BIT_OVERFLOW_FLAG       = 2;

  // Clock phases per instruction cycle and counts
  localparam logic [1:0] PHASE_TWO           = 2'h1;
  localparam logic [1:0] PHASE_FOUR          = 2'h3;
  localparam logic [1:0] WRITE_INHIBIT_CYCLES = 2'h2;
  localparam logic [7:0] COUNT_MAX           = 8'hFF;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_t;

  typedef struct packed {
    logic [1:0] phase;
    logic       pin_meta;
    logic       pin_sync;
    logic       sel_prev;
    logic       sampled;
    logic       sampled_prev;
    logic       pre_prev;
    logic       wdt_prev;
    logic [1:0] inhibit;
    logic [7:0] prescaler;
    logic [7:0] timer_count;
    logic [7:0] interrupt_control;
    logic [7:0] timer_configuration;
    logic [7:0] rdata;
    logic       irq;
    logic       wdt_out;
  } state_t;

endpackage

// *** logic/timer0_core.sv ***
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps
module timer0_core (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       external_count_input,
  input  wire logic       sleep,
  input  wire logic       watchdog_clear_instr,
  input  wire logic       watchdog_tick,
  output logic            watchdog_postscaled,
  output logic            timer_irq
);

  timer0_pkg::state_t   st;
  timer0_pkg::state_t   next_st;
  timer0_pkg::bus_req_t req;

  logic       instr_tick;
  logic       sample_now;
  logic       src_sel;
  logic       ext_edge;
  logic       prescaler_assign;
  logic       counter_mode;
  logic [2:0] ratio;
  logic       pre_bit;
  logic       timer_tick;
  logic       wr_count;
  logic       wr_interrupt_control;
  logic       wr_config;
  logic       wdt_bit;
  logic       wdt_rise;

  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  assign prescaler_assign          = st.timer_configuration[timer0_pkg::BIT_PRESCALER_ASSIGN];
  assign counter_mode = st.timer_configuration[timer0_pkg::BIT_CLOCK_SOURCE_SELECT];
  assign ratio        = st.timer_configuration[timer0_pkg::BIT_PRESCALE_RATIO_LSB +:
                                               timer0_pkg::PRESCALE_RATIO_WIDTH];
  assign instr_tick   = (st.phase == timer0_pkg::PHASE_FOUR);
  assign sample_now   = (st.phase == timer0_pkg::PHASE_TWO) ||
                        (st.phase == timer0_pkg::PHASE_FOUR);
  // Flip the synced pin so that the chosen edge is always a rise
  assign src_sel      = st.pin_sync ^
                        st.timer_configuration[timer0_pkg::BIT_SOURCE_EDGE_SELECT];
  assign ext_edge     = src_sel & ~st.sel_prev;
  assign pre_bit      = st.prescaler[ratio];
  assign wr_count     = req.wr && (req.addr == timer0_pkg::OFS_TIMER_COUNT);
  assign wr_interrupt_control    = req.wr && (req.addr == timer0_pkg::OFS_INTERRUPT_CONTROL);
  assign wr_config    = req.wr && (req.addr == timer0_pkg::OFS_TIMER_CONFIGURATION);
  // Watchdog ratio 0 means no postscale: bit below the timer's tap
  assign wdt_bit      = (ratio == 3'h0) ? watchdog_tick : st.prescaler[3'(ratio - 3'h1)];
  assign wdt_rise     = (ratio == 3'h0) ? watchdog_tick : (wdt_bit & ~st.wdt_prev);

  always_comb begin
    if (counter_mode) begin
      timer_tick = st.sampled & ~st.sampled_prev;
    end else if (prescaler_assign) begin
      timer_tick = instr_tick;
    end else begin
      timer_tick = pre_bit & ~st.pre_prev;
    end
  end

  always_comb begin
    next_st          = st;
    next_st.phase    = 2'(st.phase + 2'h1);
    next_st.pin_meta = external_count_input;
    next_st.pin_sync = st.pin_meta;
    next_st.sel_prev = src_sel;
    next_st.pre_prev = pre_bit;
    next_st.wdt_prev = wdt_bit;
    next_st.rdata    = 8'h00;
    next_st.wdt_out  = 1'b0;
    // Delay tracked every cycle so one sampled rise gives one tick only
    next_st.sampled_prev = st.sampled;

    // Sampling only at two phases keeps the count tied to the CPU cycle
    if (sample_now) begin
      next_st.sampled = prescaler_assign ? src_sel : pre_bit;
    end

    // Shared prescaler, single counter for either owner
    if (!prescaler_assign) begin
      if ((counter_mode && ext_edge) || (!counter_mode && instr_tick)) begin
        next_st.prescaler = 8'(st.prescaler + 8'h01);
      end
    end else begin
      if (watchdog_tick) begin
        next_st.prescaler = 8'(st.prescaler + 8'h01);
      end
      next_st.wdt_out = wdt_rise;
    end

    if (st.inhibit != 2'h0 && instr_tick) begin
      next_st.inhibit = 2'(st.inhibit - 2'h1);
    end

    // Sleep freezes counting, so no overflow can ever arrive to wake
    if (timer_tick && st.inhibit == 2'h0 && !sleep) begin
      next_st.timer_count = 8'(st.timer_count + 8'h01);
      if (st.timer_count == timer0_pkg::COUNT_MAX) begin
        next_st.interrupt_control[timer0_pkg::BIT_OVERFLOW_FLAG] = 1'b1;
      end
    end

    if (watchdog_clear_instr && prescaler_assign) begin
      next_st.prescaler = 8'h00;
    end

    if (wr_count) begin
      next_st.timer_count = req.wdata;
      next_st.inhibit     = timer0_pkg::WRITE_INHIBIT_CYCLES;
      if (!prescaler_assign) begin
        next_st.prescaler = 8'h00;
      end
    end

    // Flag write: a same-cycle overflow still sets it
    if (wr_interrupt_control) begin
      next_st.interrupt_control = req.wdata;
      if (timer_tick && st.inhibit == 2'h0 && !sleep &&
          st.timer_count == timer0_pkg::COUNT_MAX) begin
        next_st.interrupt_control[timer0_pkg::BIT_OVERFLOW_FLAG] = 1'b1;
      end
    end

    if (wr_config) begin
      next_st.timer_configuration = req.wdata;
    end

    // No address reaches the prescaler itself
    if (req.rd) begin
      case (req.addr)
        timer0_pkg::OFS_TIMER_COUNT:         next_st.rdata = st.timer_count;
        timer0_pkg::OFS_INTERRUPT_CONTROL:   next_st.rdata = st.interrupt_control;
        timer0_pkg::OFS_TIMER_CONFIGURATION: next_st.rdata = st.timer_configuration;
        default:                             next_st.rdata = 8'h00;
      endcase
    end

    next_st.irq = next_st.interrupt_control[timer0_pkg::BIT_OVERFLOW_IRQ_ENABLE] &
                  next_st.interrupt_control[timer0_pkg::BIT_OVERFLOW_FLAG];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st                     <= '0;
      st.timer_count         <= timer0_pkg::RST_TIMER_COUNT;
      st.interrupt_control   <= timer0_pkg::RST_INTERRUPT_CONTROL;
      st.timer_configuration <= timer0_pkg::RST_TIMER_CONFIGURATION;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign rdata               = st.rdata;
  assign timer_irq           = st.irq;
  assign watchdog_postscaled = st.wdt_out;

  // Checks
  property p_inhibit_hold;
    @(posedge clk) disable iff (rst)
      (ce && st.inhibit != 2'h0 && !wr_count) |=> (st.timer_count == $past(st.timer_count));
  endproperty
  a_inhibit_hold: assert property (p_inhibit_hold) else $error("count moved while inhibited");

  property p_write_inhibit;
    @(posedge clk) disable iff (rst)
      (ce && wr_count) |=> (st.inhibit == 2'h2) && (st.timer_count == $past(wdata));
  endproperty
  a_write_inhibit: assert property (p_write_inhibit) else $error("write did not arm inhibit");

  property p_timer_mode_step;
    @(posedge clk) disable iff (rst)
      (ce && !counter_mode && prescaler_assign && instr_tick && st.inhibit == 2'h0 && !sleep && !wr_count)
      |=> (st.timer_count == 8'($past(st.timer_count) + 8'h01));
  endproperty
  a_timer_mode_step: assert property (p_timer_mode_step) else $error("timer mode missed a step");

  property p_prescaler_step;
    @(posedge clk) disable iff (rst)
      (ce && !counter_mode && !prescaler_assign && instr_tick && !wr_count)
      |=> (st.prescaler == 8'($past(st.prescaler) + 8'h01));
  endproperty
  a_prescaler_step: assert property (p_prescaler_step) else $error("prescaler did not count");

  property p_write_clears_prescaler;
    @(posedge clk) disable iff (rst)
      (ce && wr_count && !prescaler_assign) |=> (st.prescaler == 8'h00) &&
      (st.timer_configuration == $past(st.timer_configuration));
  endproperty
  a_write_clears_prescaler: assert property (p_write_clears_prescaler) else $error("prescaler not cleared");

  property p_wdt_clear;
    @(posedge clk) disable iff (rst)
      (ce && watchdog_clear_instr && prescaler_assign && !wr_config) |=> (st.prescaler == 8'h00);
  endproperty
  a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog clear missed prescaler");

  property p_overflow_flag;
    @(posedge clk) disable iff (rst)
      (ce && $past(ce) && $past(st.timer_count) == 8'hFF && st.timer_count == 8'h00 && !$past(wr))
      |-> st.interrupt_control[timer0_pkg::BIT_OVERFLOW_FLAG];
  endproperty
  a_overflow_flag: assert property (p_overflow_flag) else $error("overflow flag not set");

  property p_irq_gate;
    @(posedge clk) disable iff (rst)
      timer_irq |-> st.interrupt_control[timer0_pkg::BIT_OVERFLOW_IRQ_ENABLE] &&
                    st.interrupt_control[timer0_pkg::BIT_OVERFLOW_FLAG];
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without enable and flag");

  property p_sleep_stop;
    @(posedge clk) disable iff (rst)
      (ce && sleep && !wr_count) |=> (st.timer_count == $past(st.timer_count));
  endproperty
  a_sleep_stop: assert property (p_sleep_stop) else $error("timer ran in sleep");

  property p_counter_sync;
    @(posedge clk) disable iff (rst)
      (ce && counter_mode && st.timer_count != $past(st.timer_count) && !$past(wr))
      |-> $past(st.sampled) && !$past(st.sampled_prev);
  endproperty
  a_counter_sync: assert property (p_counter_sync) else $error("count without synced edge");

  property p_freeze;
    @(posedge clk) disable iff (rst)
      !ce
      |=> (st == $past(st));
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved with enable low");

  property p_phase_step;
    @(posedge clk) disable iff (rst)
      ce
      |=> (st.phase == 2'($past(st.phase) + 2'h1));
  endproperty
  a_phase_step: assert property (p_phase_step) else $error("phase counter skipped");

  property p_sync_chain;
    @(posedge clk) disable iff (rst)
      ce
      |=> (st.pin_sync == $past(st.pin_meta));
  endproperty
  a_sync_chain: assert property (p_sync_chain) else $error("pin synchroniser broken");

  property p_sample_hold;
    @(posedge clk) disable iff (rst)
      (ce && !sample_now)
      |=> (st.sampled == $past(st.sampled));
  endproperty
  a_sample_hold: assert property (p_sample_hold) else $error("sample taken off phase");

  property p_step_one;
    @(posedge clk) disable iff (rst)
      (ce && !wr_count)
      |=> (st.timer_count == $past(st.timer_count)) ||
          (st.timer_count == 8'($past(st.timer_count) + 8'h01));
  endproperty
  a_step_one: assert property (p_step_one) else $error("count jumped");

  property p_flag_sticky;
    @(posedge clk) disable iff (rst)
      (ce && st.interrupt_control[timer0_pkg::BIT_OVERFLOW_FLAG] && !wr_interrupt_control)
      |=> st.interrupt_control[timer0_pkg::BIT_OVERFLOW_FLAG];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag cleared by hardware");

  property p_irq_follow;
    @(posedge clk) disable iff (rst)
      (st.interrupt_control[timer0_pkg::BIT_OVERFLOW_IRQ_ENABLE] &&
       st.interrupt_control[timer0_pkg::BIT_OVERFLOW_FLAG]) |-> timer_irq;
  endproperty
  a_irq_follow: assert property (p_irq_follow) else $error("irq missing");

  property p_wdt_owner_quiet;
    @(posedge clk) disable iff (rst)
      (ce && !prescaler_assign)
      |=> !watchdog_postscaled;
  endproperty
  a_wdt_owner_quiet: assert property (p_wdt_owner_quiet) else $error("watchdog pulse");

  property p_prescaler_owned;
    @(posedge clk) disable iff (rst)
      (ce && prescaler_assign && !watchdog_tick && !watchdog_clear_instr && !wr_config)
      |=> (st.prescaler == $past(st.prescaler));
  endproperty
  a_prescaler_owned: assert property (p_prescaler_owned) else $error("shared count moved");

  property p_config_write;
    @(posedge clk) disable iff (rst)
      (ce && wr_config)
      |=> (st.timer_configuration == $past(wdata));
  endproperty
  a_config_write: assert property (p_config_write) else $error("config not written");

  property p_rdata_idle;
    @(posedge clk) disable iff (rst)
      (ce && !rd)
      |=> (rdata == 8'h00);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");

  property p_read_count;
    @(posedge clk) disable iff (rst)
      (ce && rd && addr == timer0_pkg::OFS_TIMER_COUNT)
      |=> (rdata == $past(st.timer_count));
  endproperty
  a_read_count: assert property (p_read_count) else $error("count read wrong");

  property p_read_unmapped;
    @(posedge clk) disable iff (rst)
      (ce && rd && addr != timer0_pkg::OFS_TIMER_COUNT && addr != timer0_pkg::OFS_INTERRUPT_CONTROL &&
       addr != timer0_pkg::OFS_TIMER_CONFIGURATION) |=> (rdata == 8'h00);
  endproperty
  a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped read nonzero");

  property p_counter_hold;
    @(posedge clk) disable iff (rst)
      (ce && counter_mode && !timer_tick && !wr_count)
      |=> (st.timer_count == $past(st.timer_count));
  endproperty
  a_counter_hold: assert property (p_counter_hold) else $error("count without edge");

  property p_prescaler_hold;
    @(posedge clk) disable iff (rst)
      (ce && !prescaler_assign && !counter_mode && !instr_tick && !wr_count)
      |=> (st.prescaler == $past(st.prescaler));
  endproperty
  a_prescaler_hold: assert property (p_prescaler_hold) else $error("prescaler ran off tick");

  property p_wdt_write_keeps;
    @(posedge clk) disable iff (rst)
      (ce && wr_count && prescaler_assign && !watchdog_tick && !watchdog_clear_instr)
      |=> (st.prescaler == $past(st.prescaler));
  endproperty
  a_wdt_write_keeps: assert property (p_wdt_write_keeps) else $error("watchdog count lost");

  c_overflow:  cover property (@(posedge clk) disable iff (rst) $rose(timer_irq));
  c_counter:   cover property (@(posedge clk) disable iff (rst)
                               counter_mode && timer_tick && ce);
  c_watchdog:  cover property (@(posedge clk) disable iff (rst) watchdog_postscaled);
  c_prescaled: cover property (@(posedge clk) disable iff (rst)
                               !prescaler_assign && !counter_mode && timer_tick && ce);
  c_clear:     cover property (@(posedge clk) disable iff (rst)
                               ce && wr_count && !prescaler_assign);

endmodule

// *** tb/count_source.sv ***
`timescale 1ns/10ps
module count_source (
  input  wire logic clk,
  output logic      pin,
  output logic      tick
);
  initial begin
    pin = 1'b0;
    tick = 1'b0;
  end
  // Long hold so both sampling phases see each level
  task automatic edge_to(input logic lvl);
    @(posedge clk) pin <= lvl;
    repeat (12) @(posedge clk);
  endtask
  task automatic pulses(input int n);
    repeat (n) begin
      edge_to(1'b1);
      edge_to(1'b0);
    end
  endtask
  task automatic wd_tick();
    @(posedge clk) tick <= 1'b1;
    @(posedge clk) tick <= 1'b0;
  endtask
endmodule

// *** tb/timer0_core_tb.sv ***
`timescale 1ns/10ps
module timer0_core_tb;
  localparam logic [7:0] TC = timer0_pkg::OFS_TIMER_COUNT;
  localparam logic [7:0] IC = timer0_pkg::OFS_INTERRUPT_CONTROL;
  localparam logic [7:0] CF = timer0_pkg::OFS_TIMER_CONFIGURATION;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       ce = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] rdata;
  logic       sleep = 1'b0;
  logic       wclr = 1'b0;
  logic       wpost;
  logic       irq;
  logic       pin;
  logic       tick;
  logic [7:0] v;
  logic [7:0] v0;
  int         miscompares = 0;
  int         total_checks = 0;
  int         posts = 0;

  timer0_core i_timer0_core (.clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .external_count_input(pin), .sleep(sleep),
    .watchdog_clear_instr(wclr), .watchdog_tick(tick), .watchdog_postscaled(wpost),
    .timer_irq(irq));
  count_source i_count_source (.clk(clk), .pin(pin), .tick(tick));

  always #4 clk = ~clk;
  always @(posedge clk) if (wpost === 1'b1) posts++;

  task automatic check(input string w, input logic [7:0] seen, input logic [7:0] e);
    total_checks++;
    if (seen !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", w, e, seen);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rd_cmp(input logic [7:0] a, input logic [7:0] e, input string w);
    rd_reg(a, v);
    check(w, v, e);
  endtask
  // Difference of two reads span clocks apart; phase-independent
  task automatic rate(input int span, input logic [7:0] dlt, input string w);
    rd_reg(TC, v0);
    repeat (span - 2) @(posedge clk);
    rd_reg(TC, v);
    check(w, v - v0, dlt);
  endtask
  task automatic clr_wd();
    @(posedge clk) wclr <= 1'b1;
    @(posedge clk) wclr <= 1'b0;
  endtask
  task automatic summarize();
    $display("Checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    #200000;
    miscompares++;
    summarize();
  end

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd_cmp(TC, timer0_pkg::RST_TIMER_COUNT, "count reset");
    rd_cmp(IC, timer0_pkg::RST_INTERRUPT_CONTROL, "interrupt_control reset");
    rd_cmp(CF, timer0_pkg::RST_TIMER_CONFIGURATION, "config reset");
    rd_cmp(8'h02, 8'h00, "unmapped read");
    wr_reg(CF, 8'h0F);
    rate(16, 8'h04, "unprescaled rate");
    // Third instruction tick after the write is the first to count
    wr_reg(TC, 8'hFF);
    repeat (11) @(posedge clk);
    rd_cmp(TC, 8'h00, "inhibit and wrap");
    rd_cmp(IC, 8'h04, "overflow flag");
    check("irq masked", {7'h00, irq}, 8'h00);
    wr_reg(IC, 8'h24);
    @(posedge clk);
    #1 check("irq enabled", {7'h00, irq}, 8'h01);
    wr_reg(IC, 8'h20);
    @(posedge clk);
    #1 check("irq cleared", {7'h00, irq}, 8'h00);
    @(posedge clk) sleep <= 1'b1;
    rate(16, 8'h00, "sleep stop");
    @(posedge clk) sleep <= 1'b0;
    for (int r = 0; r < 8; r++) begin
      wr_reg(CF, {5'h00, r[2:0]});
      rate(16 << r, 8'h02, "timer prescale");
    end
    wr_reg(TC, 8'h10);
    repeat (400) @(posedge clk);
    rd_cmp(TC, 8'h10, "prescaler cleared");
    repeat (300) @(posedge clk);
    rd_cmp(TC, 8'h11, "first prescaled step");
    rd_cmp(CF, 8'h07, "assign kept");
    wr_reg(CF, 8'h28);
    repeat (12) @(posedge clk);
    wr_reg(TC, 8'h00);
    repeat (12) @(posedge clk);
    i_count_source.edge_to(1'b1);
    rd_cmp(TC, 8'h01, "rising edge");
    // Flipping edge select may fake an edge, so clear the count after
    wr_reg(CF, 8'h38);
    repeat (12) @(posedge clk);
    wr_reg(TC, 8'h00);
    repeat (12) @(posedge clk);
    i_count_source.edge_to(1'b0);
    rd_cmp(TC, 8'h01, "falling edge");
    i_count_source.pulses(4);
    rd_cmp(TC, 8'h05, "pulse train");
    wr_reg(CF, 8'h20);
    repeat (12) @(posedge clk);
    wr_reg(TC, 8'h00);
    repeat (12) @(posedge clk);
    i_count_source.pulses(4);
    rd_cmp(TC, 8'h02, "counter prescale");
    wr_reg(TC, 8'h00);
    clr_wd();
    wr_reg(CF, 8'h0A);
    #1 posts = 0;
    i_count_source.wd_tick();
    clr_wd();
    i_count_source.wd_tick();
    repeat (4) @(posedge clk);
    #1 check("watchdog clear", posts[7:0], 8'h00);
    repeat (3) i_count_source.wd_tick();
    repeat (4) @(posedge clk);
    #1 check("postscale", posts[7:0], 8'h01);
    summarize();
  end
endmodule
